// ---- msc_defs.vh ----
/*
 Constants for the modem status-change mask unit: register offsets,
 field positions, reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH

`define MSC_OFF_EVENT        8'hF0
`define MSC_OFF_MASK         8'hF4
`define MSC_OFF_PRESENT      8'hF8
`define MSC_OFF_FORCE        8'hFC

`define MSC_BIT_IRQ_GATE     15
`define MSC_BIT_WAKE_GATE    14
`define MSC_BIT_AUDIO_HI     6
`define MSC_BIT_AUDIO_LO     5
`define MSC_BIT_GENERAL_WAKE_GATE_BIT        4
`define MSC_BIT_BATT_READY   2
`define MSC_BIT_BATT_WP      1

`define MSC_MASK_WMASK       32'h0000C076
`define MSC_MASK_RESET       32'h00000000
`define MSC_PRESENT_RESET    32'h00000000
`define MSC_EVENT_RESET      32'h00000000

`endif

// ---- msc_sync2.v ----
/*
 Two-flop synchroniser for one asynchronous level.
 Assumes the input comes from a pin outside the mclk domain.
*/
`timescale 1ns/1ps
module msc_sync2 (
  // Clock and reset
  input  wire mclk,
  input  wire rstAsync,
  // Level
  input  wire din,
  output reg  dout
);

  reg stage1;

  always @(posedge mclk or posedge rstAsync) begin
    if (rstAsync) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // msc_sync2

// ---- msc_status_change.v ----
/*
 Modem function status-change unit for CardBus mode: event, mask,
 present-state and force-event registers, and the gating of the modem
 interrupt line and the CardBus status-change line.
 Assumes a simple synchronous register port on mclk (one-cycle read or
 write strobe with byte offset), and that modem pins and the power-up
 reset pin are asynchronous to mclk.
*/
// What this block does
// [RULE1] Mask bit 15 clear blocks modem interrupt; event register untouched.
// [RULE2] Interrupt asserts only with request and control-block enable set; mask bit 15 also needed in CardBus mode after a mask write.
// [RULE3] Mask bit 15 gates interrupt only after software writes the mask.
// [RULE4] Mask bit 14 clear blocks wake events toward status-change output; events untouched.
// [RULE5] Mask bit 4 clear blocks wake events toward status-change output.
// [RULE6] In CardBus mode only, status-change drives on wake AND general wake, or PME enable alone.
// [RULE7] Mask bits 6:5 hold a two-bit audio enable, reset zero.
// [RULE8] Mask bits 2 and 1 hold battery ready and write protect.
// [RULE9] Mask reserved bits 31:16, 13:7, 3 and 0 stay zero.
// [RULE10] Present bit 15 follows the modem interrupt pin live.
// [RULE11] Present bit 4 shows the inverted modem ring pin live.
// [RULE12] Present bits 2 and 1 carry battery ready and write protect.
// [RULE13] Present reserved bits 31:16, 14:5, 3 and 0 read zero.
// [RULE14] A force-event register lets software raise events.
// [RULE15] These registers act only while in CardBus mode.
// [RULE16] Power-up reset pin initialises them; software resets do not.
// [RULE17] Present writes ignored; mask writable bits read back as written.
`include "msc_defs.vh"
`timescale 1ns/1ps
module msc_status_change (
  // Clock and resets
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        alternate_power_up_reset_n,
  // Mode and enables from the rest of the controller
  input  wire        cardbusMode,
  input  wire        systemControlBlockModemEn,
  input  wire        pmeEnable,
  input  wire        modemIrqRequest,
  // Modem chipset pins
  input  wire        modem_irq_input,
  input  wire        modem_ring_input_n,
  input  wire        battery_detect_ready,
  input  wire        battery_detect_write_protect,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [31:0] regWdata,
  output reg  [31:0] regRdata,
  output reg         regRvalid,
  // Outputs
  output reg         modemIntaOut,
  output reg         cardStatusChange,
  output reg  [1:0]  pulse_audio_enable
);

  ////////////////////////////////////////////////////////////////////////
  // Reset and pin synchronisation.

  wire rstAll;
  wire irqPin;
  wire ringPin;
  wire battReady;
  wire battWp;
  wire pmeSync;

  // Power-up reset joins system reset; no software reset reaches here.
  assign rstAll = sys_rst | ~alternate_power_up_reset_n; // [RULE16]

  msc_sync2 uSyncIrq (
    .mclk     (mclk),
    .rstAsync (rstAll),
    .din      (modem_irq_input),
    .dout     (irqPin)
  );

  msc_sync2 uSyncRing (
    .mclk     (mclk),
    .rstAsync (rstAll),
    .din      (~modem_ring_input_n),
    .dout     (ringPin)
  );

  msc_sync2 uSyncBattReady (
    .mclk     (mclk),
    .rstAsync (rstAll),
    .din      (battery_detect_ready),
    .dout     (battReady)
  );

  msc_sync2 uSyncBattWp (
    .mclk     (mclk),
    .rstAsync (rstAll),
    .din      (battery_detect_write_protect),
    .dout     (battWp)
  );

  assign pmeSync = pmeEnable;

  ////////////////////////////////////////////////////////////////////////
  // Registers.

  reg  [31:0] modemEventMask;
  reg  [31:0] modemEvent;
  reg         maskWritten;
  wire [31:0] modemPresentState;
  wire        wrMask;
  wire        wrEvent;
  wire        wrForce;
  wire        irqGateBit;
  wire        wakeGateBit;
  wire        generalWakeGateBit;
  wire        maskAllowsIrq;
  wire        wakeAllowed;
  wire [31:0] liveEvents;
  wire [31:0] next_modemEvent;

  assign wrMask  = regWrite & cardbusMode &
                   (regAddr == `MSC_OFF_MASK); // [RULE15]
  assign wrEvent = regWrite & cardbusMode & (regAddr == `MSC_OFF_EVENT);
  assign wrForce = regWrite & cardbusMode & (regAddr == `MSC_OFF_FORCE);

  // Reserved mask bits are never stored, so they read zero.
  always @(posedge mclk or posedge rstAll) begin
    if (rstAll) begin
      modemEventMask <= `MSC_MASK_RESET;
      maskWritten    <= 1'b0;
    end else if (wrMask) begin
      modemEventMask <= regWdata & `MSC_MASK_WMASK; // [RULE9] [RULE17]
      maskWritten    <= 1'b1; // [RULE3]
    end
  end

  assign irqGateBit         = modemEventMask[`MSC_BIT_IRQ_GATE];
  assign wakeGateBit        = modemEventMask[`MSC_BIT_WAKE_GATE];
  assign generalWakeGateBit = modemEventMask[`MSC_BIT_GENERAL_WAKE_GATE_BIT];

  // Live event sources in present-state layout.
  assign modemPresentState = {16'h0000,
                              irqPin,                 // [RULE10]
                              10'h000,                // [RULE13]
                              ringPin,                // [RULE11]
                              1'b0,
                              battReady,              // [RULE12]
                              battWp,                 // [RULE12]
                              1'b0};
  assign liveEvents = modemPresentState;

  // Events latch from a rising source or a forced write. Set wins over
  // a write-one-to-clear in the same cycle so no event is lost. The mask
  // never touches this register.
  reg [31:0] prevSources;
  assign next_modemEvent =
    ((modemEvent & ~(wrEvent ? regWdata : 32'h00000000)) |
     (liveEvents & ~prevSources) |
     (wrForce ? (regWdata & `MSC_MASK_WMASK) : 32'h00000000)) &
    `MSC_MASK_WMASK; // [RULE1] [RULE4] [RULE5] [RULE14]

  always @(posedge mclk or posedge rstAll) begin
    if (rstAll) begin
      modemEvent  <= `MSC_EVENT_RESET;
      prevSources <= `MSC_PRESENT_RESET;
    end else begin
      prevSources <= liveEvents;
      if (cardbusMode) begin
        modemEvent <= next_modemEvent; // [RULE15]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output gating.

  // Before the first mask write, the mask bit does not block the line.
  assign maskAllowsIrq = ~maskWritten | irqGateBit; // [RULE1] [RULE3]
  assign wakeAllowed   = wakeGateBit & generalWakeGateBit &
                         (modemEvent[`MSC_BIT_GENERAL_WAKE_GATE_BIT] |
                          modemEvent[`MSC_BIT_IRQ_GATE]); // [RULE4] [RULE5]

  always @(posedge mclk or posedge rstAll) begin
    if (rstAll) begin
      modemIntaOut       <= 1'b0;
      cardStatusChange   <= 1'b0;
      pulse_audio_enable <= 2'b00;
    end else begin
      modemIntaOut     <= modemIrqRequest & systemControlBlockModemEn &
                          (~cardbusMode | maskAllowsIrq); // [RULE2]
      cardStatusChange <= cardbusMode &
                          (wakeAllowed | pmeSync); // [RULE6]
      pulse_audio_enable <= modemEventMask[`MSC_BIT_AUDIO_HI:
                                           `MSC_BIT_AUDIO_LO]; // [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port. Reads answer one cycle after the strobe.

  reg [31:0] next_regRdata;

  always @* begin
    next_regRdata = 32'h00000000;
    if (cardbusMode) begin
      case (regAddr)
        `MSC_OFF_EVENT:   next_regRdata = modemEvent;
        `MSC_OFF_MASK:    next_regRdata = modemEventMask; // [RULE8]
        `MSC_OFF_PRESENT: next_regRdata = modemPresentState; // [RULE17]
        default:          next_regRdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge mclk or posedge rstAll) begin
    if (rstAll) begin
      regRdata  <= 32'h00000000;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= next_regRdata;
      end
    end
  end

endmodule // msc_status_change

// ---- msc_status_change_monitor.sv ----
/* Port checker for the modem status-change unit.
   Bound to every msc_status_change; sees only its ports. */
`timescale 1ns/1ps
module msc_status_change_monitor (
  // Clock and resets
  input wire        mclk, sys_rst, alternate_power_up_reset_n,
  // Enables and mode
  input wire        cardbusMode, systemControlBlockModemEn,
  input wire        pmeEnable, modemIrqRequest,
  // Register port and outputs
  input wire        regWrite, regRead, regRvalid,
  input wire [7:0]  regAddr,
  input wire [31:0] regWdata, regRdata,
  input wire        modemIntaOut, cardStatusChange
);
  wire rstAny = sys_rst | ~alternate_power_up_reset_n;
  reg  live;
  // The first edge after reset would let $past see reset-time values.
  always @(posedge mclk or posedge rstAny)
    if (rstAny) live <= 1'b0;
    else live <= 1'b1;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rstAny);
////////////////////////////////////////
  irq_cause_a:
    assert property (live && modemIntaOut |-> $past(modemIrqRequest &&
      systemControlBlockModemEn)) else $error("interrupt without cause");
  irq_legacy_a:
    assert property (live && $past(modemIrqRequest && !cardbusMode &&
      systemControlBlockModemEn) |-> modemIntaOut)
      else $error("legacy interrupt lost");
  irq_masked_a:
    assert property (regWrite && cardbusMode && regAddr == 8'hF4 &&
      !regWdata[15] ##1 (!regWrite && cardbusMode)[*2] |=> !modemIntaOut)
      else $error("masked interrupt still asserted");
  csc_mode_a:
    assert property (live && $past(!cardbusMode) |-> !cardStatusChange)
      else $error("status change outside card mode");
  pme_wake_a:
    assert property (live && $past(cardbusMode && pmeEnable) |->
      cardStatusChange) else $error("power event not signalled");
  rd_valid_a:
    assert property (live && $past(regRead && cardbusMode) |-> regRvalid)
      else $error("read not answered");
  mask_resvd_a:
    assert property (live && regRvalid && $past(regAddr) == 8'hF4 |->
      (regRdata & 32'hFFFF3F89) == 32'h0) else $error("mask reserved set");
  pres_resvd_a:
    assert property (live && regRvalid && $past(regAddr) == 8'hF8 |->
      (regRdata & 32'hFFFF7FE9) == 32'h0) else $error("state reserved set");
  cover property (modemIntaOut);
  cover property (cardStatusChange);
  cover property (regWrite && regAddr == 8'hF4);
endmodule // msc_status_change_monitor
bind msc_status_change msc_status_change_monitor mon_u (.*);

// ---- msc_modem_pins.sv ----
/* Model of the modem chipset pins.
   Levels change a few ns after the bench asks, off the clock. */
`timescale 1ns/1ps
module msc_modem_pins (
  // Requests from the bench
  input wire  irqOn, ringOn, readyOn, wpOn,
  // Chipset pins
  output wire modem_irq_input, modem_ring_input_n,
  output wire battery_detect_ready, battery_detect_write_protect
);
  assign #3 modem_irq_input = irqOn;
  // The ring line is active low, so it rests high.
  assign #3 modem_ring_input_n = ~ringOn;
  assign #3 battery_detect_ready = readyOn;
  assign #3 battery_detect_write_protect = wpOn;
endmodule // msc_modem_pins

// ---- msc_status_change_tb_top.sv ----
/* Self-checking bench for the modem status-change unit.
   Assumes the checker is bound and the pin model sits beside it. */
`timescale 1ns/1ps
module msc_status_change_tb_top;
  reg mclk = 0, sys_rst = 1, alternate_power_up_reset_n = 1;
  reg cardbusMode = 1, systemControlBlockModemEn = 0, pmeEnable = 0;
  reg modemIrqRequest = 0, regWrite = 0, regRead = 0;
  reg [7:0] regAddr = 0;
  reg [31:0] regWdata = 0;
  reg irqOn = 0, ringOn = 0, readyOn = 0, wpOn = 0;
  wire modem_irq_input, modem_ring_input_n, regRvalid;
  wire battery_detect_ready, battery_detect_write_protect;
  wire [31:0] regRdata;
  wire modemIntaOut, cardStatusChange;
  wire [1:0] pulse_audio_enable;
  integer error_cnt = 0, cmp_count = 0;
  msc_status_change dut_u (.*);
  msc_modem_pins pins_u (.*);
  initial forever #5 mclk = ~mclk;
////////////////////////////////////////
  task close_out;
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1;
    cyc(1);
    regWrite = 0;
    cyc(1);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    integer i;
    regAddr = a;
    regRead = 1;
    cyc(1);
    regRead = 0;
    for (i = 0; i < 4 && regRvalid !== 1'b1; i = i + 1) cyc(1);
    if (regRvalid !== 1'b1) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
    chk(regRdata, e);
    cyc(1);
  endtask
////////////////////////////////////////
  initial begin
    cyc(5);
    sys_rst = 0;
    cyc(1);
    rd(8'hF4, 0);
    rd(8'hF8, 0);
    modemIrqRequest = 1;
    systemControlBlockModemEn = 1;
    cyc(3);
    chk(modemIntaOut, 1);
    wr(8'hF4, 32'hFFFFFFFF);
    rd(8'hF4, 32'h0000C076);
    chk(pulse_audio_enable, 2'h3);
    chk(modemIntaOut, 1);
    wr(8'hF4, 32'h00000076);
    cyc(2);
    chk(modemIntaOut, 0);
    wr(8'hF4, 32'h00008000);
    systemControlBlockModemEn = 0;
    cyc(2);
    chk(modemIntaOut, 0);
    wr(8'hF4, 32'h0000C010);
    wr(8'hF0, 32'hFFFFFFFF);
    cyc(2);
    chk(cardStatusChange, 0);
    wr(8'hFC, 32'h00000010);
    cyc(2);
    chk(cardStatusChange, 1);
    wr(8'hF4, 32'h00004000);
    cyc(2);
    chk(cardStatusChange, 0);
    wr(8'hF4, 32'h00000010);
    cyc(2);
    chk(cardStatusChange, 0);
    pmeEnable = 1;
    cyc(2);
    chk(cardStatusChange, 1);
    pmeEnable = 0;
    irqOn = 1;
    ringOn = 1;
    readyOn = 1;
    wpOn = 1;
    cyc(4);
    wr(8'hF8, 0);
    rd(8'hF8, 32'h00008016);
    irqOn = 0;
    ringOn = 0;
    cyc(4);
    rd(8'hF8, 32'h00000006);
    rd(8'h40, 0);
    systemControlBlockModemEn = 1;
    cardbusMode = 0;
    cyc(2);
    chk(cardStatusChange, 0);
    chk(modemIntaOut, 1);
    cardbusMode = 1;
    alternate_power_up_reset_n = 0;
    cyc(1);
    alternate_power_up_reset_n = 1;
    cyc(1);
    rd(8'hF4, 0);
    close_out;
  end
endmodule // msc_status_change_tb_top
